//--- shcp_far_client.sv
// Far-side client model: mode 0, echoes each byte back in the following transfer
`timescale 1ns/1ps
module shcp_far_client (
  input  wire logic sck,   // Serial clock from the host
  input  wire logic mosi,  // Host data out
  input  wire logic cs_n,  // Select, active low
  input  wire logic lsb,   // 1 = least significant bit first
  output logic      miso   // Client data out
);
  logic [7:0] sh_r;  // Outgoing byte
  logic [7:0] rx_r;  // Incoming byte
  logic       inv_r = 1'h1; // Inverse of the last bit, shown once released
  int         cnt;   // Bits taken in this byte
  // Selection restarts the byte with a fixed opening value
  always @(negedge cs_n) begin
    sh_r = 8'hA5;
    cnt = 0;
  end
  // Remember the inverse of the last bit when released
  always @(posedge cs_n) inv_r = ~miso;
  // Sample on the rising edge
  always @(posedge sck) if (!cs_n) begin
    rx_r = lsb ? {mosi, rx_r[7:1]} : {rx_r[6:0], mosi};
    cnt++;
  end
  // Shift on the falling edge; after eight bits load the echo
  always @(negedge sck) if (!cs_n) begin
    if (cnt == 8) begin
      sh_r = rx_r;
      cnt = 0;
    end else sh_r = lsb ? {1'h0, sh_r[7:1]} : {sh_r[6:0], 1'h0};
  end
  assign miso = cs_n ? inv_r : (lsb ? sh_r[0] : sh_r[7]);
endmodule

//--- shcp_pkg.sv
// Package for the serial host/client port: register map, fields, states, pin carriers
package shcp_pkg;

  // Register byte offsets
  localparam logic [7:0] CONTROL_A_REG_OFF   = 8'h00;
  localparam logic [7:0] CONTROL_B_REG_OFF   = 8'h04;
  localparam logic [7:0] IRQ_CONTROL_REG_OFF = 8'h08;
  localparam logic [7:0] IRQ_FLAG_REG_OFF    = 8'h0C;
  localparam logic [7:0] DATA_REG_OFF        = 8'h10;
  localparam logic [7:0] PIN_DIR_REG_OFF     = 8'h14;

  // Control A fields
  localparam int CA_ENABLE  = 0;
  localparam int CA_CLOCK_PRESCALER_L = 1;
  localparam int CA_CLOCK_PRESCALER_H = 2;
  localparam int CA_CLOCK_DOUBLE   = 4;
  localparam int CA_HOST    = 5;
  localparam int CA_BIT_ORDER_SELECT    = 6;
  // Control B fields
  localparam int CB_MODE_L  = 0;
  localparam int CB_MODE_H  = 1;
  localparam int CB_SSD     = 2;
  localparam int CB_BUFFER_WAIT_RECEIVE   = 6;
  localparam int CB_BUFFER_MODE_ENABLE   = 7;
  // Interrupt control / flag fields
  localparam int IC_IE      = 0;
  localparam int IC_TRANSFER_COMPLETE_IRQ_ENABLE   = 6;
  localparam int IF_DONE    = 7;
  localparam int IF_WRITE_COLLISION_FLAG   = 6;
  localparam int IF_TX_BUFFER_EMPTY_FLAG   = 5;
  localparam int IF_TRANSFER_COMPLETE_FLAG   = 6;
  localparam int IF_RECEIVE_COMPLETE_FLAG   = 7;
  // Pin direction fields (1 = output)
  localparam int PD_MOSI = 0;
  localparam int PD_MISO = 1;
  localparam int PD_SCK  = 2;
  localparam int PD_SEL  = 3;

  // Reset values
  localparam logic [7:0] CONTROL_A_RST = 8'h00;
  localparam logic [7:0] CONTROL_B_RST = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RST  = 8'h00;
  localparam logic [7:0] PIN_DIR_RST   = 8'h00;

  // Index of the last bit in a transfer (eight bits per transfer)
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Transfer engine states
  typedef enum logic [2:0] {
    SHCP_IDLE  = 3'b001,
    SHCP_HOST  = 3'b010,
    SHCP_CLNT  = 3'b100
  } shcp_state_e;

  // Pin outputs as a group: level and enable per data and clock line
  typedef struct packed {
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic sck_o;
    logic sck_oe;
  } shcp_pins_s;

endpackage

//--- shcp_port.sv
// Serial host/client port with AHB-Lite register slave
//
// Implementation choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module shcp_port
  import shcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial pins
  input  wire logic        mosi_i,
  input  wire logic        miso_i,
  input  wire logic        sck_i,
  input  wire logic        sel_n_i,
  output shcp_pins_s       pins,
  output logic             irq
);

  // Synchronisers for pin inputs
  logic [1:0] mosi_s_r;     // Host-out line
  logic [1:0] miso_s_r;     // Client-out line
  logic [1:0] sck_s_r;      // Serial clock
  logic [1:0] sel_s_r;      // Select (low active)
  logic       sck_d_r;      // Previous synced clock for edge find

  // Software registers
  logic [7:0] ctrl_a_r;     // control_a_reg
  logic [7:0] ctrl_b_r;     // control_b_reg
  logic [7:0] irq_ctl_r;    // irq_control_reg
  logic [3:0] pin_dir_r;    // Pin direction configuration

  // Engine state
  shcp_state_e state_r;     // Engine state
  logic [7:0] shift_r;      // Shift register
  logic [2:0] bit_cnt_r;    // Bit counter
  logic       half_r;       // Host: next tick is trailing edge
  logic [7:0] div_cnt_r;    // Host clock divider counter
  logic       sck_out_r;    // Host clock level
  logic       out_bit_r;    // Current data-out bit
  logic [7:0] txbuf_r;      // Transmit buffer
  logic       txbuf_full_r; // Transmit buffer holds a byte
  logic       dummy_r;      // Client: shifter holds dummy byte
  logic [7:0] rx0_r;        // Receive data / FIFO head
  logic [7:0] rx1_r;        // FIFO second entry
  logic [1:0] rx_cnt_r;     // FIFO fill count
  logic       done_r;       // Transfer done flag (normal mode)
  logic       write_collision_flag_r;      // write_collision_flag
  logic       receive_complete_flag_r;      // receive_complete_flag
  logic       transfer_complete_flag_r;      // transfer_complete_flag
  logic       dre_rise_r;   // Empty flag just set, stages receive flag
  logic       rx_rise_r;    // Receive flag just set, stages complete flag

  // AHB address phase capture
  logic       wr_ph_r;      // Write data phase pending
  logic [7:0] addr_r;       // Captured address

  // Named controls
  wire enable     = ctrl_a_r[CA_ENABLE];
  wire host       = ctrl_a_r[CA_HOST];
  wire lsb_first  = ctrl_a_r[CA_BIT_ORDER_SELECT];   // bit_order_select
  wire clock_double      = ctrl_a_r[CA_CLOCK_DOUBLE];  // clock_double
  wire [1:0] clock_prescaler = ctrl_a_r[CA_CLOCK_PRESCALER_H:CA_CLOCK_PRESCALER_L];
  wire buffer_mode_enable      = ctrl_b_r[CB_BUFFER_MODE_ENABLE];
  wire buffer_wait_receive      = ctrl_b_r[CB_BUFFER_WAIT_RECEIVE];
  wire select_pin_disable        = ctrl_b_r[CB_SSD];
  wire sel_n      = sel_s_r[1];
  wire sck_s      = sck_s_r[1];
  wire sin_bit    = host ? miso_s_r[1] : mosi_s_r[1];
  wire cpha       = ctrl_b_r[CB_MODE_L];
  wire cpol       = ctrl_b_r[CB_MODE_H];
  wire busy       = (state_r != SHCP_IDLE);

  // Bus decode
  wire bus_req = hsel && htrans[1] && hready;
  wire rd_req  = bus_req && !hwrite;
  wire wr_data = wr_ph_r;
  wire wr_ca   = wr_data && addr_r == CONTROL_A_REG_OFF;
  wire wr_cb   = wr_data && addr_r == CONTROL_B_REG_OFF;
  wire wr_ic   = wr_data && addr_r == IRQ_CONTROL_REG_OFF;
  wire wr_if   = wr_data && addr_r == IRQ_FLAG_REG_OFF;
  wire wr_dat  = wr_data && addr_r == DATA_REG_OFF;
  wire wr_pd   = wr_data && addr_r == PIN_DIR_REG_OFF;
  wire rd_dat  = rd_req && haddr == DATA_REG_OFF;
  wire [7:0] wbyte = hwdata[7:0];

  // Bit selection for shifting: first bit out and bit position in
  function automatic logic pick_out(input logic [7:0] d, input logic lsb);
    pick_out = lsb ? d[0] : d[7];
  endfunction
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b,
                                          input logic lsb);
    shift_in = lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction

  // Host clock divider terminal count
  wire [7:0] div_full = 8'h02 << {clock_prescaler, 1'b0};
  // Half period of 2..128 cycles, halved by clock_double, never zero
  wire [7:0] div_half = clock_double ? (div_full >> 1) : div_full;
  wire       tick     = (div_cnt_r >= div_half - 8'h01);

  // Client edges from synced clock
  wire sck_rise  = sck_s && !sck_d_r;
  wire sck_fall  = !sck_s && sck_d_r;
  wire lead_edge = cpol ? sck_fall : sck_rise;
  wire trail_edge = cpol ? sck_rise : sck_fall;
  wire samp_edge  = cpha ? trail_edge : lead_edge;
  wire shft_edge  = cpha ? lead_edge : trail_edge;

  // Multi-host takeover
  wire takeover = enable && host && !select_pin_disable && !pin_dir_r[PD_SEL] && !sel_n;

  // Host transfer engine steps
  // Input bit taken on the trailing edge: the two-cycle synchroniser lag still shows
  // the bit that stood before it; a one-cycle half period is too short for that
  wire host_samp = state_r == SHCP_HOST && tick && half_r;
  wire host_last = state_r == SHCP_HOST && tick && half_r && bit_cnt_r == BIT_LAST;
  // Client transfer engine steps
  wire cl_act    = enable && !host && !sel_n;
  wire cl_samp   = cl_act && samp_edge;
  wire cl_last   = cl_samp && bit_cnt_r == BIT_LAST;
  wire xfer_end  = host_last || cl_last;
  // Received byte as it completes
  wire [7:0] rx_byte = shift_in(shift_r, sin_bit, lsb_first);

  // Data write routing
  wire host_start = wr_dat && enable && host && !busy && (!buffer_mode_enable || !txbuf_full_r);
  wire to_txbuf   = wr_dat && enable && buffer_mode_enable && !txbuf_full_r &&
                    !(host && !busy);
  wire collide    = wr_dat && enable && !buffer_mode_enable && busy;
  // Client normal, idle: write loads shifter directly
  wire cl_load    = wr_dat && enable && !host && !buffer_mode_enable && !busy;
  // Buffer into shifter: after transfer, or when deselected with wait-receive 1
  wire buf_move   = enable && buffer_mode_enable && txbuf_full_r &&
                    ((xfer_end && !(host_last && 1'b0)) ||
                     (!host && buffer_wait_receive && sel_n && !busy));
  wire tx_empty   = buffer_mode_enable && !busy && !txbuf_full_r && !to_txbuf;

  // Pin inputs pass two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mosi_s_r <= 2'b00;
      miso_s_r <= 2'b00;
      sck_s_r  <= 2'b00;
      sel_s_r  <= 2'b11;
      sck_d_r  <= 1'b0;
    end else begin
      mosi_s_r <= {mosi_s_r[0], mosi_i};
      miso_s_r <= {miso_s_r[0], miso_i};
      sck_s_r  <= {sck_s_r[0], sck_i};
      sel_s_r  <= {sel_s_r[0], sel_n_i};
      sck_d_r  <= sck_s_r[1];
    end
  end

  // AHB data-phase capture; slave is always ready, OKAY response
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ph_r <= 1'b0;
      addr_r  <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else begin
      wr_ph_r <= bus_req && hwrite;
      addr_r  <= haddr;
      if (rd_req) begin
        case (haddr)
          CONTROL_A_REG_OFF:   hrdata <= {24'h000000, ctrl_a_r};
          CONTROL_B_REG_OFF:   hrdata <= {24'h000000, ctrl_b_r};
          IRQ_CONTROL_REG_OFF: hrdata <= {24'h000000, irq_ctl_r};
          IRQ_FLAG_REG_OFF:    hrdata <= buffer_mode_enable ?
              {24'h000000, receive_complete_flag_r, transfer_complete_flag_r, !txbuf_full_r, write_collision_flag_r, 4'h0} :
              {24'h000000, done_r, write_collision_flag_r, 6'h00};
          DATA_REG_OFF:        hrdata <= {24'h000000, rx0_r};
          PIN_DIR_REG_OFF:     hrdata <= {28'h0000000, pin_dir_r};
          default:             hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Control registers; takeover clears the host bit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_a_r  <= CONTROL_A_RST;
      ctrl_b_r  <= CONTROL_B_RST;
      irq_ctl_r <= IRQ_CTRL_RST;
      pin_dir_r <= PIN_DIR_RST[3:0];
    end else begin
      if (wr_ca) ctrl_a_r <= wbyte;
      if (takeover) ctrl_a_r[CA_HOST] <= 1'b0;
      if (wr_cb) ctrl_b_r <= wbyte;
      if (wr_ic) irq_ctl_r <= wbyte;
      if (wr_pd) pin_dir_r <= wbyte[3:0];
    end
  end

  // Transfer engine: state, counters, shifter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r   <= SHCP_IDLE;
      shift_r   <= 8'h00;
      bit_cnt_r <= 3'h0;
      half_r    <= 1'b0;
      div_cnt_r <= 8'h00;
      sck_out_r <= 1'b0;
      out_bit_r <= 1'b0;
      dummy_r   <= 1'b0;
    end else begin
      div_cnt_r <= (state_r == SHCP_HOST && !tick) ? div_cnt_r + 8'h01 : 8'h00;
      case (state_r)
        SHCP_IDLE: begin
          sck_out_r <= cpol;
          bit_cnt_r <= 3'h0;
          half_r    <= 1'b0;
          if (host_start || cl_load) begin
            shift_r   <= wbyte;
            out_bit_r <= pick_out(wbyte, lsb_first);
            dummy_r   <= 1'b0;
          end else if (buf_move) begin
            shift_r   <= txbuf_r;
            out_bit_r <= pick_out(txbuf_r, lsb_first);
          end
          if (host_start) state_r <= SHCP_HOST;
          else if (cl_act) begin
            state_r   <= SHCP_CLNT;
            out_bit_r <= pick_out(shift_r, lsb_first);
            dummy_r   <= buffer_mode_enable && !buffer_wait_receive && !txbuf_full_r;
          end
        end
        SHCP_HOST: begin
          if (takeover) state_r <= SHCP_IDLE;
          else if (tick) begin
            sck_out_r <= !sck_out_r;
            half_r    <= !half_r;
            if (host_samp) shift_r <= rx_byte;
            if (half_r != cpha) out_bit_r <= pick_out(half_r ? rx_byte : shift_r, lsb_first);
            if (half_r) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              if (host_last) begin
                state_r <= buf_move ? SHCP_HOST : SHCP_IDLE;
                if (buf_move) begin
                  shift_r   <= txbuf_r;
                  out_bit_r <= pick_out(txbuf_r, lsb_first);
                end
                sck_out_r <= cpol;
              end
            end
          end
        end
        SHCP_CLNT: begin
          if (sel_n || host || !enable) begin
            state_r   <= SHCP_IDLE;
            bit_cnt_r <= 3'h0;
          end else if (cl_samp) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (cl_last && buf_move) begin
              shift_r <= txbuf_r;
              out_bit_r <= pick_out(txbuf_r, lsb_first);
            end
          end else if (shft_edge) begin
            out_bit_r <= pick_out(shift_r, lsb_first);
          end
        end
        default: state_r <= SHCP_IDLE;
      endcase
    end
  end

  // Transmit buffer: load while empty, release into shifter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      txbuf_r      <= 8'h00;
      txbuf_full_r <= 1'b0;
    end else if (!buffer_mode_enable) begin
      txbuf_full_r <= 1'b0;
    end else if (to_txbuf) begin
      txbuf_r      <= wbyte;
      txbuf_full_r <= 1'b1;
    end else if (buf_move) begin
      txbuf_full_r <= 1'b0;
    end
  end

  // Receive path: holding register or two-entry FIFO
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx0_r    <= 8'h00;
      rx1_r    <= 8'h00;
      rx_cnt_r <= 2'h0;
    end else if (!buffer_mode_enable) begin
      rx_cnt_r <= 2'h0;
      if (xfer_end) rx0_r <= rx_byte;
    end else begin
      case ({xfer_end, rd_dat && rx_cnt_r != 2'h0})
        2'b10: begin
          if (rx_cnt_r == 2'h0) rx0_r <= rx_byte;
          else rx1_r <= rx_byte;                // Overwrites newest when full
          if (rx_cnt_r != 2'h2) rx_cnt_r <= rx_cnt_r + 2'h1;
        end
        2'b01: begin
          rx0_r    <= rx1_r;
          rx_cnt_r <= rx_cnt_r - 2'h1;
        end
        2'b11: begin
          if (rx_cnt_r == 2'h1) rx0_r <= rx_byte;
          else begin
            rx0_r <= rx1_r;
            rx1_r <= rx_byte;
          end
        end
        default: rx_cnt_r <= rx_cnt_r;
      endcase
    end
  end

  // Flags: hardware set beats software clear (write 1 to clear)
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_r     <= 1'b0;
      write_collision_flag_r    <= 1'b0;
      receive_complete_flag_r    <= 1'b0;
      transfer_complete_flag_r    <= 1'b0;
      dre_rise_r <= 1'b0;
      rx_rise_r  <= 1'b0;
    end else begin
      dre_rise_r <= enable && buffer_mode_enable && xfer_end;
      rx_rise_r  <= dre_rise_r;
      done_r  <= (enable && !buffer_mode_enable && xfer_end) || takeover ||
                 (done_r && !(wr_if && wbyte[IF_DONE]));
      write_collision_flag_r <= collide || (write_collision_flag_r && !(wr_if && wbyte[IF_WRITE_COLLISION_FLAG]));
      receive_complete_flag_r <= dre_rise_r || (receive_complete_flag_r && !(rd_dat || (wr_if && wbyte[IF_RECEIVE_COMPLETE_FLAG])));
      transfer_complete_flag_r <= (rx_rise_r && tx_empty) ||
                 (transfer_complete_flag_r && !(wr_if && wbyte[IF_TRANSFER_COMPLETE_FLAG]));
    end
  end

  // Interrupt request from enabled flags
  assign irq = (!buffer_mode_enable && irq_ctl_r[IC_IE] && done_r) ||
               (buffer_mode_enable && irq_ctl_r[IC_TRANSFER_COMPLETE_IRQ_ENABLE] && transfer_complete_flag_r) ||
               (buffer_mode_enable && irq_ctl_r[IC_IE] && receive_complete_flag_r);

  // Pin drive: role inputs forced, port owns output levels
  assign pins.mosi_o  = out_bit_r;
  assign pins.mosi_oe = enable && host && pin_dir_r[PD_MOSI];
  assign pins.sck_o   = sck_out_r;
  assign pins.sck_oe  = enable && host && pin_dir_r[PD_SCK];
  assign pins.miso_o  = out_bit_r;
  assign pins.miso_oe = enable && !host && pin_dir_r[PD_MISO] && !sel_n;

endmodule

//--- shcp_port_chk.sv
// Checker for the serial port's bus answers, pin drivers and interrupt line
`timescale 1ns/1ps
module shcp_port_chk
  import shcp_pkg::*;
(
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        sel_n_i,
  input wire shcp_pins_s  pins,
  input wire logic        irq
);
  logic       wr_r;   // Write data phase in progress
  logic       rd_r;   // Read data phase in progress
  logic [7:0] adr_r;  // Address of the current data phase
  logic [7:0] ca_r;   // Mirror of control A
  logic [7:0] ic_r;   // Mirror of interrupt control
  logic [7:0] pd_r;   // Mirror of pin directions
  logic       dwr;    // Data word written while enabled as host with the clock pin set as output
  logic       unmap;  // Read of an unmapped word

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // Decode the events the assertions hang on
  assign dwr   = wr_r && adr_r == DATA_REG_OFF && ca_r[CA_ENABLE] && ca_r[CA_HOST]
                 && pd_r[PD_SCK];
  assign unmap = rd_r && adr_r > PIN_DIR_REG_OFF;

  // Follow the bus phases and mirror the control writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r  <= 1'h0;
      rd_r  <= 1'h0;
      adr_r <= 8'h00;
      ca_r  <= CONTROL_A_RST;
      ic_r  <= IRQ_CTRL_RST;
      pd_r  <= PIN_DIR_RST;
    end else begin
      if (hready) begin
        wr_r  <= hsel && htrans[1] && hwrite;
        rd_r  <= hsel && htrans[1] && !hwrite;
        adr_r <= haddr;
      end
      if (wr_r && adr_r == CONTROL_A_REG_OFF) ca_r <= hwdata[7:0];
      if (wr_r && adr_r == IRQ_CONTROL_REG_OFF) ic_r <= hwdata[7:0];
      if (wr_r && adr_r == PIN_DIR_REG_OFF) pd_r <= hwdata[7:0];
    end
  end

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_unmap_zero: assert property (unmap |-> hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  chk_upper_zero: assert property (rd_r |-> hrdata[31:8] == 24'h0)
    else $error("upper read bits nonzero");
  chk_mosi_miso_excl: assert property (pins.mosi_oe |-> !pins.miso_oe)
    else $error("both data lines driven");
  chk_sck_miso_excl: assert property (pins.sck_oe |-> !pins.miso_oe)
    else $error("clock and client data both driven");
  chk_dir_gates_oe: assert property ((pins.mosi_oe |-> pd_r[PD_MOSI]) and
    (pins.sck_oe |-> pd_r[PD_SCK]) and (pins.miso_oe |-> pd_r[PD_MISO]))
    else $error("pin driven while set as input");
  chk_miso_desel: assert property (sel_n_i [*5] |-> !pins.miso_oe)
    else $error("client data driven while deselected");
  chk_irq_masked: assert property (!ic_r[IC_IE] && !ic_r[IC_TRANSFER_COMPLETE_IRQ_ENABLE] |-> !irq)
    else $error("interrupt raised while disabled");
  chk_host_start: assert property (dwr |-> ##[1:600] $changed(pins.sck_o))
    else $error("host data write started no clock");
endmodule

bind shcp_port shcp_port_chk u_shcp_port_chk (
  .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sel_n_i(sel_n_i), .pins(pins), .irq(irq)
);

//--- testbench.sv
// Self-checking bench for the serial host/client port
`timescale 1ns/1ps
module testbench;
  import shcp_pkg::*;
  logic        clk;
  logic        resetn = 1'h0;  // Reset, active low
  logic [1:0]  htrans = 2'h0;  // Bus transfer kind
  logic [7:0]  haddr  = 8'h00; // Bus address
  logic        hwrite = 1'h0;  // Bus direction
  logic [31:0] hwdata = 32'h0; // Bus write data
  logic        t_mosi = 1'h0;  // Bench host data to the client port
  logic        t_sck  = 1'h0;  // Bench host clock, 64 ns period
  logic        sel_n  = 1'h1;  // Select pin level, active low
  logic        cs_n   = 1'h1;  // Far client select, active low
  logic        lsb    = 1'h0;  // Far client bit order
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, irq, p_miso, mosi_ln, miso_ln, sck_ln;
  shcp_pins_s  pins;
  int          bad_count = 0;  // Mismatches
  int          tests_run = 0;  // Comparisons
  logic [31:0] rd;             // Last read data
  logic [7:0]  d, e, m, got;   // Bytes sent, echo expected, host byte, client bits seen

  // Resolve the shared lines from the drivers' enables
  assign mosi_ln = pins.mosi_oe ? pins.mosi_o : t_mosi;
  assign sck_ln  = pins.sck_oe ? pins.sck_o : t_sck;
  assign miso_ln = pins.miso_oe ? pins.miso_o : p_miso;

  shcp_port u_shcp_port (
    .clk(clk), .resetn(resetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mosi_i(mosi_ln), .miso_i(miso_ln),
    .sck_i(sck_ln), .sel_n_i(sel_n), .pins(pins), .irq(irq));
  shcp_far_client u_shcp_far_client (
    .sck(sck_ln), .mosi(mosi_ln), .cs_n(cs_n), .lsb(lsb), .miso(p_miso));

  // Free-running system clock
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Compare one value against its expectation
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'h1 && n < 100);
    rd = hrdata;
    if (n >= 100) begin
      bad_count++;
      conclude();
    end
  endtask

  // Poll one register bit until it reaches a value, bounded
  task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin bus(1'h0, a, 32'h0); n++; end while (rd[b] !== v && n < 2000);
    if (n >= 2000) begin
      bad_count++;
      conclude();
    end
  endtask

  // One mode 0 bit from the bench host, 4 cycles per phase
  task automatic cbit(input logic v);
    t_mosi <= v;
    repeat (4) @(posedge clk);
    t_sck <= 1'h1;
    repeat (3) @(posedge clk);
    got = {got[6:0], miso_ln};
    @(posedge clk);
    t_sck <= 1'h0;
  endtask

  initial begin
    void'($urandom(32'hB6E1BA3E));
    repeat (5) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    // Reset values and an unmapped word
    bus(1'h0, CONTROL_A_REG_OFF, 32'h0); check(rd, 32'(CONTROL_A_RST));
    bus(1'h0, CONTROL_B_REG_OFF, 32'h0); check(rd, 32'(CONTROL_B_RST));
    bus(1'h0, IRQ_CONTROL_REG_OFF, 32'h0); check(rd, 32'(IRQ_CTRL_RST));
    bus(1'h0, PIN_DIR_REG_OFF, 32'h0); check(rd, 32'(PIN_DIR_RST));
    bus(1'h0, 8'h18 + 8'(4 * ($urandom % 58)), 32'h0); check(rd, 32'h0);
    // Host, normal mode: select pin low but ignored or an output
    cs_n <= 1'h0;
    e = 8'hA5;
    bus(1'h1, IRQ_CONTROL_REG_OFF, 32'h01);
    for (int i = 0; i < 6; i++) begin
      lsb <= i[1];
      bus(1'h1, CONTROL_B_REG_OFF, i[0] ? 32'h04 : 32'h00);
      bus(1'h1, PIN_DIR_REG_OFF, i[0] ? 32'h05 : 32'h0D);
      // Doubled rate at prescaler 0 is left out: too short for the input synchroniser
      bus(1'h1, CONTROL_A_REG_OFF, {24'h0, 1'h0, i[1], 1'h1, 1'($urandom) & (i % 4 != 0),
                                    1'h0, 2'(i % 4), 1'h1});
      d = 8'($urandom);
      sel_n <= 1'h0;
      bus(1'h1, DATA_REG_OFF, {24'h0, d});
      wait_bit(IRQ_FLAG_REG_OFF, IF_DONE, 1'h1);
      sel_n <= 1'h1;
      check(32'(irq), 32'h1);
      bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, e});
      e = d;
      bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
      @(posedge clk);
      check(32'(irq), 32'h0);
    end
    // Early write collides
    bus(1'h1, DATA_REG_OFF, {24'h0, d});
    bus(1'h1, DATA_REG_OFF, {24'h0, ~d});
    wait_bit(IRQ_FLAG_REG_OFF, IF_DONE, 1'h1);
    check(32'(rd[IF_WRITE_COLLISION_FLAG]), 32'h1);
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    cs_n <= 1'h1;
    @(posedge clk);
    cs_n <= 1'h0;
    // Unread byte is overwritten by the next one
    d = 8'($urandom);
    bus(1'h1, DATA_REG_OFF, {24'h0, d});
    wait_bit(IRQ_FLAG_REG_OFF, IF_DONE, 1'h1);
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    bus(1'h1, DATA_REG_OFF, {24'h0, ~d});
    wait_bit(IRQ_FLAG_REG_OFF, IF_DONE, 1'h1);
    bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, d});
    e = ~d;
    // Host, buffered mode with wait-receive set
    bus(1'h1, CONTROL_B_REG_OFF, 32'hC0);
    bus(1'h1, IRQ_CONTROL_REG_OFF, 32'h40);
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    d = 8'($urandom);
    bus(1'h1, DATA_REG_OFF, {24'h0, d});
    bus(1'h1, DATA_REG_OFF, {24'h0, ~d});
    wait_bit(IRQ_FLAG_REG_OFF, IF_TRANSFER_COMPLETE_FLAG, 1'h1);
    check(32'(rd[IF_TX_BUFFER_EMPTY_FLAG]), 32'h1);
    check(32'(irq), 32'h1);
    bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, e});
    bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, d});
    // Select pulled low by another host forces client role
    sel_n <= 1'h1;
    bus(1'h1, CONTROL_B_REG_OFF, 32'h00);
    bus(1'h1, PIN_DIR_REG_OFF, 32'h05);
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    sel_n <= 1'h0;
    wait_bit(CONTROL_A_REG_OFF, CA_HOST, 1'h0);
    bus(1'h0, IRQ_FLAG_REG_OFF, 32'h0); check(32'(rd[IF_DONE]), 32'h1);
    // Client, normal mode, with a write in mid-byte
    cs_n <= 1'h1;
    sel_n <= 1'h1;
    bus(1'h1, PIN_DIR_REG_OFF, 32'h02);
    bus(1'h1, CONTROL_A_REG_OFF, 32'h01);
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    d = 8'($urandom);
    m = 8'($urandom);
    bus(1'h1, DATA_REG_OFF, {24'h0, d});
    check(32'(pins.miso_oe), 32'h0);
    sel_n <= 1'h0;
    for (int i = 7; i > 4; i--) cbit(m[i]);
    bus(1'h1, DATA_REG_OFF, {24'h0, ~d});
    for (int i = 4; i >= 0; i--) cbit(m[i]);
    check({24'h0, got}, {24'h0, d});
    bus(1'h0, IRQ_FLAG_REG_OFF, 32'h0); check({30'h0, rd[7:6]}, 32'h3);
    bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, m});
    // Deselect in mid-byte drops the partial byte
    bus(1'h1, IRQ_FLAG_REG_OFF, 32'hC0);
    for (int i = 0; i < 3; i++) cbit(1'($urandom));
    sel_n <= 1'h1;
    bus(1'h0, IRQ_FLAG_REG_OFF, 32'h0); check(32'(rd[IF_DONE]), 32'h0);
    sel_n <= 1'h0;
    m = 8'($urandom);
    for (int i = 7; i >= 0; i--) cbit(m[i]);
    bus(1'h0, DATA_REG_OFF, 32'h0); check(rd, {24'h0, m});
    // Client buffered, wait-receive set: user byte goes out first
    sel_n <= 1'h1;
    bus(1'h1, CONTROL_B_REG_OFF, 32'hC0);
    d = 8'($urandom);
    bus(1'h1, DATA_REG_OFF, {24'h0, d});
    sel_n <= 1'h0;
    for (int i = 0; i < 8; i++) cbit(1'($urandom));
    check({24'h0, got}, {24'h0, d});
    conclude();
  end
endmodule
